// ==== src/uart_stat_params.svh ====
// Register offsets, field positions, reset values and codes for the status block.
`ifndef UART_STAT_PARAMS_SVH
`define UART_STAT_PARAMS_SVH
`define RX_ERROR_STATUS_ADDR 16'hFF53
`define TX_STATUS_ADDR 16'hFF55
`define BASE_CLOCK_SELECT_ADDR 16'hFF56
`define PARITY_ERROR_BIT 2
`define FRAMING_ERROR_BIT 1
`define OVERRUN_BIT 0
`define TX_BUFFER_FULL_BIT 1
`define TX_SHIFTING_BIT 0
`define STATUS_RESET 8'h00
`define CLOCK_SELECT_RESET 4'h0
`define CLOCK_SELECT_MAX_DIV 4'hA
`define CLOCK_SELECT_TIMER 4'hB
`define READ_WAIT_CYCLES 1
`endif

// ==== src/uart_stat_pkg.sv ====
// Types shared by the status and clock select block.
package uart_stat_pkg;
	// Parity handling modes as held in the operation mode register.
	typedef enum logic [1:0] {
		PARITY_NONE = 2'h0,
		PARITY_ZERO = 2'h1,
		PARITY_ODD = 2'h2,
		PARITY_EVEN = 2'h3
	} parity_mode_type;
	// One finished character from the receive shifter.
	typedef struct packed {
		logic done;
		logic [7:0] data;
		logic parity_bit;
		logic stop_bit;
	} rx_char_type;
	// Control bits of the operation mode register.
	typedef struct packed {
		logic unit_power_control;
		logic transmit_enable_bit;
		logic receive_enable_bit;
		parity_mode_type parity_mode;
		logic char_eight_bits;
	} mode_ctrl_type;
endpackage

// ==== src/uart_base_clock.sv ====
// Base clock enable generator: power-of-two divider or timer output.
`timescale 1ns/1ns
module uart_base_clock #(
	parameter int DIV_WIDTH = 10
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic run,
	input wire logic [3:0] select,
	input wire logic timer_tick,
	output logic base_tick
);
`include "uart_stat_params.svh"
	// Free-running prescaler; runs only while the unit is powered.
	logic [DIV_WIDTH-1:0] cnt_q;
	logic [DIV_WIDTH-1:0] cnt_d;
	logic tick_d;
	logic tick_q;

	// Mask of low bits that must all be one for a divided tick.
	function automatic logic [DIV_WIDTH-1:0] div_mask(input logic [3:0] s);
		div_mask = DIV_WIDTH'((11'h001 << s) - 11'h001);
	endfunction

	// Next count and tick; the count never resets on a rewrite of the
	// same code, so a refresh does not disturb the clock.
	always_comb begin
		cnt_d = run ? cnt_q + DIV_WIDTH'(1) : '0;
		tick_d = 1'b0;
		if (run) begin
			if (select <= `CLOCK_SELECT_MAX_DIV) begin
				tick_d = (cnt_q & div_mask(select)) == div_mask(select);
			end else if (select == `CLOCK_SELECT_TIMER) begin
				tick_d = timer_tick;
			end
		end
	end

	// Registers of the prescaler.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (clk_en) begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end
	assign base_tick = tick_q;

	// Power off must hold the tick low.
	tick_idle_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && !run |=> !base_tick)
		else $error("tick while off");
endmodule

// ==== src/uart_rx_check.sv ====
// Receive character checker: parity, framing and overrun flags.
`timescale 1ns/1ns
module uart_rx_check (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic active,
	input wire uart_stat_pkg::parity_mode_type parity_mode,
	input wire logic char_eight_bits,
	input wire uart_stat_pkg::rx_char_type rx_char,
	input wire logic buffer_read,
	input wire logic status_read,
	output logic [2:0] error_flags,
	output logic [7:0] receive_buffer
);
`include "uart_stat_params.svh"
	logic [2:0] flags_q;
	logic [2:0] flags_d;
	logic [7:0] buf_q;
	logic [7:0] buf_d;
	logic unread_q;
	logic unread_d;
	logic par_bad;
	logic overrun;

	// Parity of the data bits, seven or eight wide.
	function automatic logic data_parity(input logic [7:0] d, input logic w8);
		data_parity = w8 ? ^d : ^d[6:0];
	endfunction

	// Flag and buffer update; set wins over a same-cycle read clear.
	always_comb begin
		flags_d = flags_q;
		buf_d = buf_q;
		unread_d = unread_q;
		par_bad = 1'b0;
		unique case (parity_mode)
			uart_stat_pkg::PARITY_ODD: par_bad =
				data_parity(rx_char.data, char_eight_bits) ==
				rx_char.parity_bit;
			uart_stat_pkg::PARITY_EVEN: par_bad =
				data_parity(rx_char.data, char_eight_bits) !=
				rx_char.parity_bit;
			uart_stat_pkg::PARITY_NONE,
			uart_stat_pkg::PARITY_ZERO: par_bad = 1'b0;
		endcase
		overrun = rx_char.done && unread_q && !buffer_read;
		if (status_read) begin
			flags_d = 3'h0;
		end
		if (buffer_read) begin
			unread_d = 1'b0;
		end
		if (rx_char.done) begin
			if (par_bad) begin
				flags_d[`PARITY_ERROR_BIT] = 1'b1;
			end
			if (!rx_char.stop_bit) begin
				flags_d[`FRAMING_ERROR_BIT] = 1'b1;
			end
			if (overrun) begin
				flags_d[`OVERRUN_BIT] = 1'b1;
			end else begin
				buf_d = rx_char.data;
				unread_d = 1'b1;
			end
		end
		if (!active) begin
			flags_d = 3'h0;
			unread_d = 1'b0;
			buf_d = 8'hFF;
		end
	end

	// Registers of the checker.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flags_q <= 3'h0;
			buf_q <= 8'hFF;
			unread_q <= 1'b0;
		end else if (clk_en) begin
			flags_q <= flags_d;
			buf_q <= buf_d;
			unread_q <= unread_d;
		end
	end
	assign error_flags = flags_q;
	assign receive_buffer = buf_q;

	// An overrun keeps the old buffer contents.
	overrun_keeps_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && active && overrun |=> flags_q[`OVERRUN_BIT] &&
		buf_q == $past(buf_q))
		else $error("overrun lost");
	// Zero parity mode never raises a parity error, whatever arrives.
	zero_parity_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && active && parity_mode == uart_stat_pkg::PARITY_ZERO &&
		!flags_q[`PARITY_ERROR_BIT] |=> !flags_q[`PARITY_ERROR_BIT])
		else $error("parity in zero mode");
endmodule

// ==== src/uart_status_clock_select.sv ====
// Status registers and base clock select of the serial unit.
`timescale 1ns/1ns
module uart_status_clock_select (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire uart_stat_pkg::mode_ctrl_type mode_ctrl,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_wait,
	input wire logic tx_buffer_write,
	input wire logic frame_end,
	output logic tx_load,
	input wire uart_stat_pkg::rx_char_type rx_char,
	input wire logic rx_buffer_read,
	output logic [7:0] receive_buffer,
	input wire logic timer_in,
	output logic base_tick,
	output logic [3:0] clock_select
);
`include "uart_stat_params.svh"
	////////////////////////////////////////////////////////////////////////
	// Enables and decode.
	////////////////////////////////////////////////////////////////////////
	logic power;
	logic rx_active;
	logic tx_active;
	logic sel_err;
	logic sel_tx;
	logic sel_cks;
	logic [2:0] err_flags;
	logic [1:0] timer_sync_q;
	logic timer_prev_q;
	logic timer_tick;

	// Unit is active for a direction when powered and enabled.
	assign power = mode_ctrl.unit_power_control;
	assign rx_active = power && mode_ctrl.receive_enable_bit;
	assign tx_active = power && mode_ctrl.transmit_enable_bit;
	assign sel_err = cpu_addr == `RX_ERROR_STATUS_ADDR;
	assign sel_tx = cpu_addr == `TX_STATUS_ADDR;
	assign sel_cks = cpu_addr == `BASE_CLOCK_SELECT_ADDR;

	////////////////////////////////////////////////////////////////////////
	// Clock select register.
	////////////////////////////////////////////////////////////////////////
	logic [3:0] cks_q;
	logic [3:0] cks_d;

	// Whole-byte write; high bits are not stored and read as zero.
	always_comb begin
		cks_d = cks_q;
		if (cpu_wr && sel_cks) begin
			cks_d = cpu_wdata[3:0];
		end
	end

	// Clock select register storage.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cks_q <= `CLOCK_SELECT_RESET;
		end else if (clk_en) begin
			cks_q <= cks_d;
		end
	end
	assign clock_select = cks_q;

	// Timer output arrives from another block; synchronise and edge-detect.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			timer_sync_q <= 2'h0;
			timer_prev_q <= 1'b0;
		end else if (clk_en) begin
			timer_sync_q <= {timer_sync_q[0], timer_in};
			timer_prev_q <= timer_sync_q[1];
		end
	end
	assign timer_tick = timer_sync_q[1] && !timer_prev_q;

	// Base clock generator.
	uart_base_clock #(
		.DIV_WIDTH(10)
	) u_base_clock (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.run(power),
		.select(cks_q),
		.timer_tick(timer_tick),
		.base_tick(base_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Reception error status.
	////////////////////////////////////////////////////////////////////////
	logic wait_q;
	logic wait_d;
	logic err_read;

	// Error register read takes one wait cycle; clear on the completing read.
	always_comb begin
		wait_d = 1'b0;
		if (cpu_rd && sel_err && !wait_q) begin
			wait_d = 1'b1;
		end
	end
	assign cpu_wait = cpu_rd && sel_err && !wait_q;
	assign err_read = clk_en && cpu_rd && sel_err && wait_q;

	// Wait state register.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wait_q <= 1'b0;
		end else if (clk_en) begin
			wait_q <= wait_d;
		end
	end

	// Receive flag checker.
	uart_rx_check u_rx_check (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.active(rx_active),
		.parity_mode(mode_ctrl.parity_mode),
		.char_eight_bits(mode_ctrl.char_eight_bits),
		.rx_char(rx_char),
		.buffer_read(rx_buffer_read),
		.status_read(err_read),
		.error_flags(err_flags),
		.receive_buffer(receive_buffer)
	);

	////////////////////////////////////////////////////////////////////////
	// Transmission status.
	////////////////////////////////////////////////////////////////////////
	logic full_q;
	logic full_d;
	logic shift_q;
	logic shift_d;

	// Buffer moves to shifter when shifter is free or a frame ends.
	assign tx_load = tx_active && full_q && (!shift_q || frame_end);

	// Flag updates; write sets full even while a load clears it.
	always_comb begin
		full_d = full_q;
		shift_d = shift_q;
		if (tx_load) begin
			full_d = 1'b0;
			shift_d = 1'b1;
		end else if (frame_end) begin
			shift_d = 1'b0;
		end
		if (tx_buffer_write) begin
			full_d = 1'b1;
		end
		if (!tx_active) begin
			full_d = 1'b0;
			shift_d = 1'b0;
		end
	end

	// Status flag storage; CPU writes never reach it.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			full_q <= 1'b0;
			shift_q <= 1'b0;
		end else if (clk_en) begin
			full_q <= full_d;
			shift_q <= shift_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data.
	////////////////////////////////////////////////////////////////////////
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// Read mux; unmapped or reserved bits read zero.
	always_comb begin
		rdata_d = 8'h00;
		if (sel_err) begin
			rdata_d = {5'h00, err_flags};
		end else if (sel_tx) begin
			rdata_d = {6'h00, full_q, shift_q};
		end else if (sel_cks) begin
			rdata_d = {4'h0, cks_q};
		end
	end

	// Registered read data.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_q <= `STATUS_RESET;
		end else if (clk_en) begin
			rdata_q <= rdata_d;
		end
	end
	assign cpu_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	////////////////////////////////////////////////////////////////////////
	// An idle receiver holds all error flags at zero.
	rx_idle_zero_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && !rx_active |=> err_flags == 3'h0)
		else $error("rx flags not cleared");

	// An idle transmitter holds both status flags at zero.
	tx_idle_zero_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && !tx_active |=> !full_q && !shift_q)
		else $error("tx flags not cleared");

	// A completing status read with no new character clears the flags.
	read_clears_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		err_read && !rx_char.done |=> err_flags == 3'h0)
		else $error("read did not clear");

	// A status read waits for exactly one cycle, then completes.
	read_waits_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && cpu_rd && sel_err && !wait_q |-> cpu_wait ##1 !cpu_wait)
		else $error("no wait on read");

	// A buffer write while enabled sets the full flag.
	full_sets_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && tx_active && tx_buffer_write |=> full_q)
		else $error("full not set");

	// A load with no new write moves the byte into the shifter.
	load_shifts_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && tx_load && !tx_buffer_write ##0 tx_active |=>
		shift_q && !full_q)
		else $error("load failed");

	// A frame that ends with nothing waiting drops the shifting flag.
	shift_clear_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && frame_end && !full_q |=> !shift_q)
		else $error("shift flag stuck");

	// A waiting byte follows the ending frame with no idle cycle.
	gapless_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && full_q && shift_q && frame_end && tx_active |->
		tx_load ##1 shift_q)
		else $error("gap in stream");

	// A character without its first stop bit sets the framing flag.
	framing_sets_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && rx_active && rx_char.done && !rx_char.stop_bit |=>
		err_flags[`FRAMING_ERROR_BIT])
		else $error("framing lost");

	// An eight-bit character with wrong odd or even parity sets the flag.
	parity_flag_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && rx_active && rx_char.done && mode_ctrl.char_eight_bits &&
		mode_ctrl.parity_mode[1] &&
		(^rx_char.data ^ rx_char.parity_bit) == mode_ctrl.parity_mode[0]
		|=> err_flags[`PARITY_ERROR_BIT])
		else $error("parity error lost");

	// A whole-byte write lands in the select field.
	cks_write_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && cpu_wr && sel_cks |=> cks_q == $past(cpu_wdata[3:0]))
		else $error("select write lost");

	// A write to the transmit status place leaves its full flag alone.
	status_wr_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && cpu_wr && sel_tx && !tx_buffer_write && !tx_load &&
		!frame_end && tx_active |=> $stable(full_q))
		else $error("status written");

	// The undivided code gives a tick on every enabled cycle.
	undivided_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && power && cks_q == 4'h0 |=> base_tick)
		else $error("undivided clock missing");

	// The timer code passes each rising timer edge on as one base tick.
	timer_tick_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && power && cks_q == `CLOCK_SELECT_TIMER |=>
		base_tick == $past(timer_tick))
		else $error("timer tick not routed");

	// Codes above the timer code give no base clock at all.
	unused_code_a: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		clk_en && cks_q > `CLOCK_SELECT_TIMER |=> !base_tick)
		else $error("tick on unused code");

	// Main scenarios: a byte stream, an overrun, a status read, the timer
	// clock and a parity error.
	stream_c: cover property (@(posedge core_clk) tx_load ##[1:40] tx_load);
	overrun_c: cover property (@(posedge core_clk) err_flags[0]);
	err_read_c: cover property (@(posedge core_clk) err_read);
	timer_c: cover property (@(posedge core_clk)
		cks_q == `CLOCK_SELECT_TIMER && base_tick);
	parity_c: cover property (@(posedge core_clk)
		err_flags[`PARITY_ERROR_BIT]);
endmodule

// ==== sim/uart_far_end.sv ====
// Far-side transceiver model: transmit frame timing and received characters.
`timescale 1ns/1ns
module uart_far_end #(
	parameter int FRAME_CYCLES = 24
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic tx_load,
	output logic frame_end,
	output uart_stat_pkg::rx_char_type rx_char,
	output int load_count
);
	// Cycles left in the frame on the line; zero while the line is idle.
	int left_q;

	// Outputs hold defined values before the first clock edge.
	initial begin
		frame_end = 1'b0;
		rx_char = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// A load starts a frame and the last frame cycle reports its end.
	always @(posedge core_clk) begin
		if (sys_rst) begin
			left_q <= 0;
			frame_end <= 1'b0;
			load_count <= 0;
		end else begin
			frame_end <= (left_q == 2);
			if (tx_load) begin
				left_q <= FRAME_CYCLES;
				load_count <= load_count + 1;
			end else if (left_q > 0) begin
				left_q <= left_q - 1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Hands over one finished character; the stop field is the first stop
	// position only, and released fields then show inverted values.
	task automatic send_char(input logic [7:0] d, input logic p,
		input logic s);
		@(posedge core_clk);
		rx_char <= '{1'b1, d, p, s};
		@(posedge core_clk);
		rx_char <= '{1'b0, ~d, ~p, ~s};
	endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench of the status and base clock select block.
`timescale 1ns/1ns
module testbench;
	logic core_clk = 1'b0; // Bench clock.
	logic sys_rst = 1'b1; // Reset, held for the first cycles.
	uart_stat_pkg::mode_ctrl_type mode = '0; // Operation mode bits.
	logic [15:0] cpu_addr = 16'h0000; // Register address.
	logic cpu_rd = 1'b0; // Read strobe.
	logic cpu_wr = 1'b0; // Write strobe.
	logic [7:0] cpu_wdata = 8'h00; // Write data.
	logic [7:0] cpu_rdata; // Read data.
	logic cpu_wait; // Read wait request.
	logic tx_buffer_write = 1'b0; // Transmit buffer written.
	logic frame_end; // Frame finished on the line.
	logic tx_load; // Buffer moves into the shifter.
	uart_stat_pkg::rx_char_type rx_char; // Finished character.
	logic rx_buffer_read = 1'b0; // Receive buffer read.
	logic [7:0] receive_buffer; // Receive buffer contents.
	logic timer_in = 1'b0; // Timer output.
	logic base_tick; // Base clock enable.
	logic [3:0] clock_select; // Select field.
	int load_count; // Loads seen by the far side.
	logic [7:0] exp_q[$]; // Expected read data, oldest first.
	logic sample_q = 1'b0; // Read data is settled this cycle.
	int errors = 0; // Mismatches.
	int n_compared = 0; // Comparisons.
	int cyc = 0; // Cycle count for the timeout.
	int seed; // Random seed.
	logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'hB, 4'hC};
	logic [7:0] rates [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h08, 8'h00};

	uart_status_clock_select uart_status_clock_select_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.mode_ctrl(mode), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
		.cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.cpu_wait(cpu_wait), .tx_buffer_write(tx_buffer_write),
		.frame_end(frame_end), .tx_load(tx_load), .rx_char(rx_char),
		.rx_buffer_read(rx_buffer_read), .receive_buffer(receive_buffer),
		.timer_in(timer_in), .base_tick(base_tick),
		.clock_select(clock_select));
	uart_far_end uart_far_end_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .tx_load(tx_load),
		.frame_end(frame_end), .rx_char(rx_char), .load_count(load_count));

	// Clock of 4 ns period.
	always #2 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////
	// Timer output toggles every four cycles; the timeout cuts a hang.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		timer_in <= cyc[2];
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end

	// Compares settled read data with the oldest expectation.
	always @(negedge core_clk) begin
		if (sample_q) begin
			check("cpu_rdata", cpu_rdata, exp_q.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reports a mismatch between a seen and an expected value.
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask

	// Read cycle; the error status read is held for its wait cycle.
	task automatic rd(input logic [15:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		@(posedge core_clk);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		#1 check("cpu_wait", {7'h00, cpu_wait}, {7'h00, a == 16'hFF53});
		repeat ((a == 16'hFF53) ? 2 : 1) @(posedge core_clk);
		cpu_rd <= 1'b0;
		sample_q <= 1'b1;
		@(posedge core_clk);
		sample_q <= 1'b0;
	endtask

	// Write cycle of one register byte.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge core_clk);
		cpu_wr <= 1'b0;
	endtask

	// Sets the mode bits with eight-bit characters.
	task automatic set_mode(input logic p, input logic t, input logic r,
		input uart_stat_pkg::parity_mode_type pm);
		@(posedge core_clk);
		mode <= '{p, t, r, pm, 1'b1};
	endtask

	// One-cycle pulse on the transmit buffer write or buffer read line.
	task automatic pulse(input logic is_tx);
		@(posedge core_clk);
		if (is_tx) tx_buffer_write <= 1'b1;
		else rx_buffer_read <= 1'b1;
		@(posedge core_clk);
		tx_buffer_write <= 1'b0;
		rx_buffer_read <= 1'b0;
	endtask

	// Counts base clock enables over a 64-cycle window.
	task automatic count_ticks(input logic [7:0] want);
		int n;
		n = 0;
		repeat (64) begin
			@(negedge core_clk);
			if (base_tick === 1'b1) n++;
		end
		check("base_tick count", n[7:0], want);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence of scenarios.
	initial begin
		logic [7:0] v;
		logic p;
		logic s;
		logic pe;
		seed = 42795;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		// Reset values, an unmapped place and ignored status writes.
		rd(16'hFF53, 8'h00);
		rd(16'hFF55, 8'h00);
		rd(16'hFF56, 8'h00);
		rd(16'hFF54, 8'h00);
		wr(16'hFF55, 8'hFF);
		rd(16'hFF55, 8'h00);
		// Whole-byte select writes with power off read back the field.
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(16'hFF56, v);
			rd(16'hFF56, {4'h0, v[3:0]});
			check("clock_select", {4'h0, clock_select}, v & 8'h0F);
		end
		// Base clock rates for divided, timer and unused codes.
		for (int i = 0; i < 7; i++) begin
			set_mode(1'b0, 1'b0, 1'b0, uart_stat_pkg::PARITY_NONE);
			wr(16'hFF56, {4'h0, codes[i]});
			set_mode(1'b1, 1'b0, 1'b0, uart_stat_pkg::PARITY_NONE);
			repeat (8) @(posedge core_clk);
			count_ticks(rates[i]);
		end
		// Rewriting the current value in mid-run keeps the rate.
		set_mode(1'b0, 1'b0, 1'b0, uart_stat_pkg::PARITY_NONE);
		wr(16'hFF56, 8'h03);
		set_mode(1'b1, 1'b1, 1'b1, uart_stat_pkg::PARITY_NONE);
		repeat (8) @(posedge core_clk);
		fork
			count_ticks(8'h08);
			wr(16'hFF56, 8'h03);
		join
		// Parity and stop checks in every parity mode, with clearing reads.
		for (int i = 0; i < 8; i++) begin
			set_mode(1'b1, 1'b0, 1'b1,
				uart_stat_pkg::parity_mode_type'(i[1:0]));
			v = $random(seed);
			p = $random(seed);
			s = $random(seed);
			pe = (i[1] == 1'b1) && (p !== ((^v) ^ (i[1:0] == 2'h2)));
			uart_far_end_i.send_char(v, p, s);
			rd(16'hFF53, {5'h00, pe, ~s, 1'b0});
			rd(16'hFF53, 8'h00);
			check("receive_buffer", receive_buffer, v);
			pulse(1'b0);
		end
		// Overrun keeps the old character; status writes are ignored.
		set_mode(1'b1, 1'b0, 1'b1, uart_stat_pkg::PARITY_NONE);
		uart_far_end_i.send_char(8'h5A, 1'b0, 1'b1);
		uart_far_end_i.send_char(8'hA5, 1'b0, 1'b1);
		wr(16'hFF53, 8'h00);
		rd(16'hFF53, 8'h01);
		check("receive_buffer", receive_buffer, 8'h5A);
		pulse(1'b0);
		// Power and receive enable off clear a pending framing flag.
		uart_far_end_i.send_char(8'h33, 1'b0, 1'b0);
		set_mode(1'b0, 1'b0, 1'b0, uart_stat_pkg::PARITY_NONE);
		rd(16'hFF53, 8'h00);
		// Back-to-back transmission, checking the full flag after each write.
		set_mode(1'b1, 1'b1, 1'b0, uart_stat_pkg::PARITY_NONE);
		pulse(1'b1);
		rd(16'hFF55, 8'h01);
		wr(16'hFF55, 8'hFF);
		pulse(1'b1);
		rd(16'hFF55, 8'h03);
		for (int k = 0; k < 100 && load_count < 2; k++) begin
			@(posedge core_clk);
		end
		rd(16'hFF55, 8'h01);
		repeat (40) @(posedge core_clk);
		rd(16'hFF55, 8'h00);
		check("tx loads", load_count[7:0], 8'h02);
		// Transmit enable off clears the flags of a pending byte.
		pulse(1'b1);
		set_mode(1'b1, 1'b0, 1'b0, uart_stat_pkg::PARITY_NONE);
		rd(16'hFF55, 8'h00);
		repeat (4) @(posedge core_clk);
		wrap_up();
	end
endmodule
